// *** hw/nand_host_seq.sv ***
/*
 * Host-side NAND bus sequencer: runs one command, data-in or data-out cycle,
 * or a run of address cycles per request, checks the command against the legal set
 * and the busy/write-protect state, and packs addresses into cycles.
 * Assumes the user waits for req_ready_o before each new request.
 */
`timescale 1ns/1ps
`include "nand_host_defs.svh"

module nand_host_seq #(
  parameter int STROBE_CYC = `STROBE_CYC
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  // configuration
  input  wire logic        word_mode_i,
  input  wire logic        wp_allow_i,
  // request
  input  wire logic        req_valid_i,
  output logic             req_ready_o,
  input  wire logic [1:0]  req_kind_i,
  input  wire logic [7:0]  req_cmd_i,
  input  wire logic [30:0] req_addr_i,
  input  wire logic        req_row_only_i,
  input  wire logic        req_col_only_i,
  input  wire logic [15:0] req_wdata_i,
  // answer
  output logic             done_o,
  output logic             refused_o,
  output logic [15:0]      rdata_o,
  output logic             busy_o,
  // nand pins
  output logic             cle_o,
  output logic             ale_o,
  output logic             chip_sel_n_o,
  output logic             write_strobe_n_o,
  output logic             read_strobe_n_o,
  output logic             write_protect_n_o,
  output logic [15:0]      io_o,
  output logic             io_oe_o,
  input  wire logic [15:0] io_i,
  input  wire logic        ready_busy_n_i
);

  // ==========================================================
  // input synchronisers
  logic [1:0]  rb_sync;
  logic [15:0] io_meta;
  logic [15:0] io_sync;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rb_sync <= 2'h0;
      io_meta <= 16'h0000;
      io_sync <= 16'h0000;
    end else begin
      rb_sync <= {rb_sync[0], ready_busy_n_i};
      io_meta <= io_i;
      io_sync <= io_meta;
    end
  end

  assign busy_o = ~rb_sync[1];

  // ==========================================================
  // command legality
  function automatic logic cmd_known(input logic [7:0] c);
    unique case (c)
      `CMD_READ, `CMD_READ_CONF, `CMD_READ_CB, `CMD_RAND_OUT,
      `CMD_RAND_2P, `CMD_RAND_CONF, `CMD_PROG, `CMD_PROG_CB,
      `CMD_PROG_2P, `CMD_PROG_CONF, `CMD_PROG_NEXT, `CMD_ERASE,
      `CMD_ERASE_CONF, `CMD_ERASE_NEXT, `CMD_STATUS, `CMD_STATUS_ENH,
      `CMD_READ_ID, `CMD_PARAM, `CMD_UID, `CMD_GET_FEAT,
      `CMD_SET_FEAT, `CMD_RESET: cmd_known = 1'b1;
      default: cmd_known = 1'b0;
    endcase
  endfunction : cmd_known

  function automatic logic cmd_writes(input logic [7:0] c);
    cmd_writes = (c == `CMD_PROG) || (c == `CMD_PROG_CB) ||
                 (c == `CMD_PROG_2P) || (c == `CMD_PROG_CONF) ||
                 (c == `CMD_PROG_NEXT) || (c == `CMD_ERASE) ||
                 (c == `CMD_ERASE_CONF) || (c == `CMD_ERASE_NEXT);
  endfunction : cmd_writes

  logic busy_ok;
  logic wp_ok;
  logic plane_bad;
  logic page_bad;
  logic req_bad;

  assign busy_ok = (req_cmd_i == `CMD_RESET) ||
                   (req_cmd_i == `CMD_STATUS) ||
                   (req_cmd_i == `CMD_STATUS_ENH);
  assign wp_ok   = wp_allow_i || !cmd_writes(req_cmd_i);
  assign req_bad = ((req_kind_i == nand_host_pkg::OP_CMD) &&
                    (!cmd_known(req_cmd_i) || !wp_ok ||
                     (busy_o && !busy_ok))) || plane_bad || page_bad;

  // ==========================================================
  // address scope guard: copy-back target plane, random column page
  logic       plane_bit;
  logic [7:0] prev_cmd;
  logic [1:0] cand_mask;
  logic [1:0] src_mask;
  logic       cmd_take;
  logic       addr_take;

  assign plane_bit = word_mode_i ? req_addr_i[`PLANE_BIT_WORD] :
                                   req_addr_i[`PLANE_BIT_BYTE];
  assign cmd_take  = req_valid_i && req_ready_o && !req_bad &&
                     (req_kind_i == nand_host_pkg::OP_CMD);
  assign addr_take = req_valid_i && req_ready_o && !req_bad &&
                     (req_kind_i == nand_host_pkg::OP_ADDR) &&
                     !req_col_only_i;
  assign plane_bad = (req_kind_i == nand_host_pkg::OP_ADDR) &&
                     !req_col_only_i && (src_mask != 2'h0) &&
                     (prev_cmd == `CMD_PROG_CB ||
                      prev_cmd == `CMD_PROG_2P) &&
                     !src_mask[plane_bit];
  assign page_bad  = (req_kind_i == nand_host_pkg::OP_ADDR) &&
                     !req_col_only_i &&
                     (prev_cmd == `CMD_RAND_OUT);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prev_cmd  <= `CMD_RESET;
      cand_mask <= 2'h0;
      src_mask  <= 2'h0;
    end else if (cmd_take) begin
      prev_cmd <= req_cmd_i;
      // a fresh read opens a new set of source planes
      if (req_cmd_i == `CMD_READ && prev_cmd != `CMD_READ) begin
        cand_mask <= 2'h0;
      end
      if (req_cmd_i == `CMD_READ_CB) begin
        src_mask <= cand_mask;
      end else if (req_cmd_i == `CMD_READ_CONF ||
                   req_cmd_i == `CMD_PROG || req_cmd_i == `CMD_RESET) begin
        src_mask <= 2'h0;
      end
    end else if (addr_take && prev_cmd == `CMD_READ) begin
      cand_mask <= cand_mask | (2'h1 << plane_bit);
    end
  end

  // ==========================================================
  // address packing into cycle bytes
  logic [7:0] addr_byte [5];

  always_comb begin
    if (word_mode_i) begin
      addr_byte[0] = req_addr_i[7:0];
      addr_byte[1] = {5'h00, req_addr_i[10:8]};
      addr_byte[2] = req_addr_i[18:11];
      addr_byte[3] = req_addr_i[26:19];
      addr_byte[4] = {5'h00, req_addr_i[29:27]};
    end else begin
      addr_byte[0] = req_addr_i[7:0];
      addr_byte[1] = {4'h0, req_addr_i[11:8]};
      addr_byte[2] = req_addr_i[19:12];
      addr_byte[3] = req_addr_i[27:20];
      addr_byte[4] = {5'h00, req_addr_i[30:28]};
    end
  end

  // ==========================================================
  // bus cycle state machine
  nand_host_pkg::bus_state_e state;
  nand_host_pkg::op_kind_e   kind;
  logic [7:0]                timer;
  logic [2:0]                cyc_idx;
  logic [2:0]                cyc_last;
  logic [7:0]                lat_byte [5];
  logic [15:0]               wdata;

  localparam logic [7:0] STROBE_LEN = 8'(STROBE_CYC);

  assign req_ready_o = (state == nand_host_pkg::ST_IDLE);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state    <= nand_host_pkg::ST_IDLE;
      kind     <= nand_host_pkg::OP_CMD;
      timer    <= 8'h00;
      cyc_idx  <= 3'h0;
      cyc_last <= 3'h0;
      wdata    <= 16'h0000;
      done_o    <= 1'b0;
      refused_o <= 1'b0;
      for (int i = 0; i < 5; i++) begin
        lat_byte[i] <= 8'h00;
      end
    end else begin
      done_o    <= 1'b0;
      refused_o <= 1'b0;
      unique case (state)
        nand_host_pkg::ST_IDLE: begin
          if (req_valid_i) begin
            if (req_bad) begin
              refused_o <= 1'b1;
            end else begin
              kind  <= nand_host_pkg::op_kind_e'(req_kind_i);
              wdata <= (req_kind_i == nand_host_pkg::OP_CMD) ?
                       {8'h00, req_cmd_i} : req_wdata_i;
              for (int i = 0; i < 5; i++) begin
                lat_byte[i] <= addr_byte[i];
              end
              // column-only gives 2 cycles, row-only starts at cycle 3
              cyc_idx  <= req_row_only_i ? 3'h2 : 3'h0;
              cyc_last <= req_col_only_i ? 3'h1 : 3'h4;
              timer    <= STROBE_LEN;
              state    <= nand_host_pkg::ST_SETUP;
            end
          end
        end
        nand_host_pkg::ST_SETUP: begin
          timer <= STROBE_LEN;
          state <= nand_host_pkg::ST_LOW;
        end
        nand_host_pkg::ST_LOW: begin
          if (timer == 8'h01) begin
            timer <= STROBE_LEN;
            state <= nand_host_pkg::ST_HIGH;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        nand_host_pkg::ST_HIGH: begin
          if (timer == 8'h01) begin
            if (kind == nand_host_pkg::OP_ADDR && cyc_idx != cyc_last) begin
              cyc_idx <= cyc_idx + 3'h1;
              state   <= nand_host_pkg::ST_SETUP;
            end else begin
              state <= nand_host_pkg::ST_DONE;
            end
          end else begin
            timer <= timer - 8'h01;
          end
        end
        nand_host_pkg::ST_DONE: begin
          done_o <= 1'b1;
          state  <= nand_host_pkg::ST_IDLE;
        end
        default: state <= nand_host_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // read data capture in the done state, after the read strobe high phase
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else if (state == nand_host_pkg::ST_DONE &&
                 kind == nand_host_pkg::OP_RD) begin
      rdata_o <= word_mode_i ? io_sync : {8'h00, io_sync[7:0]};
    end
  end

  // ==========================================================
  // pin drive
  logic active;
  logic strobe_low;

  assign active     = (state != nand_host_pkg::ST_IDLE);
  assign strobe_low = (state == nand_host_pkg::ST_LOW);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cle_o             <= 1'b0;
      ale_o             <= 1'b0;
      chip_sel_n_o      <= 1'b1;
      write_strobe_n_o  <= 1'b1;
      read_strobe_n_o   <= 1'b1;
      write_protect_n_o <= 1'b0;
      io_o              <= 16'h0000;
      io_oe_o           <= 1'b0;
    end else begin
      write_protect_n_o <= wp_allow_i;
      chip_sel_n_o      <= !active;
      cle_o   <= active && kind == nand_host_pkg::OP_CMD;
      ale_o   <= active && kind == nand_host_pkg::OP_ADDR;
      // data out: latches low, write strobe high, read strobe toggles
      read_strobe_n_o  <= !(strobe_low &&
                            kind == nand_host_pkg::OP_RD);
      // device latches on the rising edge at end of low phase
      write_strobe_n_o <= !(strobe_low &&
                            kind != nand_host_pkg::OP_RD);
      io_oe_o <= active && kind != nand_host_pkg::OP_RD;
      unique case (kind)
        nand_host_pkg::OP_ADDR: io_o <= {8'h00, lat_byte[cyc_idx]};
        nand_host_pkg::OP_CMD:  io_o <= {8'h00, wdata[7:0]};
        nand_host_pkg::OP_WR:   io_o <= word_mode_i ? wdata :
                                        {8'h00, wdata[7:0]};
        nand_host_pkg::OP_RD:   io_o <= 16'h0000;
      endcase
    end
  end

endmodule : nand_host_seq

// *** hw/nand_host_defs.svh ***
/*
 * Constants of the host-side NAND bus sequencer: command codes, address
 * cycle layout and strobe timing counts.
 * Assumes a 100 MHz system clock; included by bare name.
 */
// Contract
// - byte mode, five address cycles: two column cycles A0-A11, three row cycles.
// - unused address bit positions are driven low by the host.
// - word mode: column A0-A10 in two cycles, row A11-A29 in three.
// - word mode plane select is A17; upper byte low during address cycles.
// - no cross-die commands except reset or status before completion.
// - command cycle CLE high ALE low; address swapped; CE low, RE high.
// - data out: both latches low, CE low, WE high, RE toggles.
// - reads: 00h addr 30h, copy-back 35h, two-plane repeats 00h.
// - program 80h..10h, copy-back 85h..10h, two-plane closes first with 11h.
// - erase 60h row D0h; two-plane 60h 60h D0h or 60h D1h 60h D0h.
// - random output 05h E0h, two-plane 06h E0h, random input 85h.
// - random data commands stay within the loaded page; the host checks this only after 05h, not after 06h or 85h.
// - only defined command codes are ever issued.
// - copy-back source and destination stay in the same plane.
// - device latches command and address on write strobe rising edge.
`ifndef NAND_HOST_DEFS_SVH
`define NAND_HOST_DEFS_SVH

`define CMD_READ        8'h00
`define CMD_READ_CONF   8'h30
`define CMD_READ_CB     8'h35
`define CMD_RAND_OUT    8'h05
`define CMD_RAND_2P     8'h06
`define CMD_RAND_CONF   8'hE0
`define CMD_PROG        8'h80
`define CMD_PROG_CB     8'h85
`define CMD_PROG_2P     8'h81
`define CMD_PROG_CONF   8'h10
`define CMD_PROG_NEXT   8'h11
`define CMD_ERASE       8'h60
`define CMD_ERASE_CONF  8'hD0
`define CMD_ERASE_NEXT  8'hD1
`define CMD_STATUS      8'h70
`define CMD_STATUS_ENH  8'h78
`define CMD_READ_ID     8'h90
`define CMD_PARAM       8'hEC
`define CMD_UID         8'hED
`define CMD_GET_FEAT    8'hEE
`define CMD_SET_FEAT    8'hEF
`define CMD_RESET       8'hFF

`define ADDR_CYCLES     3'h5
`define COL_BITS_BYTE   12
`define COL_BITS_WORD   11
`define PLANE_BIT_BYTE  18
`define PLANE_BIT_WORD  17

`define STROBE_NS       20
`define CLK_NS          10
`define STROBE_CYC      ((`STROBE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** hw/nand_host_pkg.sv ***
/*
 * Types of the host-side NAND bus sequencer.
 * Assumes nand_host_defs.svh is compiled alongside.
 */
package nand_host_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_LOW   = 3'b011,
    ST_HIGH  = 3'b010,
    ST_DONE  = 3'b110
  } bus_state_e;

  typedef enum logic [1:0] {
    OP_CMD  = 2'h0,
    OP_ADDR = 2'h1,
    OP_WR   = 2'h2,
    OP_RD   = 2'h3
  } op_kind_e;
endpackage : nand_host_pkg

// *** verif/nand_host_seq_checker.sv ***
/* Assertions on the ports of the host NAND bus sequencer.
   Assumes the default two-cycle strobe; bound to nand_host_seq below. */
`timescale 1ns/1ps
module nand_host_seq_checker #(
  parameter int STROBE_CYC = 2
) (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  // user side
  input wire logic        word_mode_i,
  input wire logic        wp_allow_i,
  input wire logic        req_valid_i,
  input wire logic        req_ready_o,
  input wire logic [1:0]  req_kind_i,
  input wire logic [7:0]  req_cmd_i,
  input wire logic        done_o,
  input wire logic        refused_o,
  input wire logic        busy_o,
  // pins
  input wire logic        cle_o,
  input wire logic        ale_o,
  input wire logic        chip_sel_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        read_strobe_n_o,
  input wire logic        write_protect_n_o,
  input wire logic [15:0] io_o,
  input wire logic        io_oe_o
);
  // ==========================================================
  // request decode
  logic [7:0] last_cmd;
  wire take = req_valid_i && req_ready_o && req_kind_i == 2'h0;
  wire known = req_cmd_i inside {8'h00, 8'h05, 8'h06, 8'h10, 8'h11,
    8'h30, 8'h35, 8'h60, 8'h70, 8'h78, 8'h80, 8'h81, 8'h85, 8'h90,
    8'hD0, 8'hD1, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'hFF};
  wire pe = req_cmd_i inside {8'h10, 8'h11, 8'h60, 8'h80, 8'h81,
    8'h85, 8'hD0, 8'hD1};
  wire any_time = req_cmd_i inside {8'hFF, 8'h70, 8'h78};
  wire legal = known && !(pe && !wp_allow_i) && !(busy_o && !any_time);
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) last_cmd <= 8'h00;
    else if (take) last_cmd <= req_cmd_i;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // ==========================================================
  // properties
  sequence cmd_on_bus;
    cle_o && io_o[7:0] == last_cmd;
  endsequence
  sequence we_pulse;
    !write_strobe_n_o [*2] ##1 write_strobe_n_o;
  endsequence
  cmd_lines_a: assert property (
    cle_o |-> !ale_o && !chip_sel_n_o && read_strobe_n_o)
    else $error("command cycle with wrong strobes");
  addr_lines_a: assert property (
    ale_o |-> !cle_o && !chip_sel_n_o && read_strobe_n_o)
    else $error("address cycle with wrong strobes");
  data_out_a: assert property (
    !read_strobe_n_o |-> !cle_o && !ale_o && !chip_sel_n_o
      && write_strobe_n_o)
    else $error("read strobe with wrong strobes");
  cmd_latch_a: assert property (
    take && legal |-> ##[1:3] cmd_on_bus ##1 we_pulse ##[1:4] done_o)
    else $error("legal command not sent");
  undef_refuse_a: assert property (
    take && !known |=> refused_o ##1 chip_sel_n_o [*2])
    else $error("undefined command not refused");
  busy_refuse_a: assert property (
    take && known && busy_o && !any_time |=> refused_o)
    else $error("command while busy not refused");
  wp_refuse_a: assert property (
    take && pe && !wp_allow_i |=> refused_o)
    else $error("program or erase not refused");
  wp_high_a: assert property (
    wp_allow_i [*2] |=> write_protect_n_o)
    else $error("write protect pin stuck low");
  wp_low_a: assert property (
    !wp_allow_i [*2] |-> !write_protect_n_o)
    else $error("write protect pin stuck high");
  upper_low_a: assert property (
    ale_o && word_mode_i |-> io_o[15:8] == 8'h00)
    else $error("upper byte not low in address cycle");
  bus_turn_a: assert property (
    !read_strobe_n_o |-> !io_oe_o)
    else $error("host drives bus during read strobe");
  bus_drive_a: assert property (
    cle_o || ale_o |-> io_oe_o)
    else $error("command or address not driven");
endmodule : nand_host_seq_checker

bind nand_host_seq nand_host_seq_checker #(.STROBE_CYC(STROBE_CYC)) chk (
  .sys_clk_i, .rst_b_i, .word_mode_i, .wp_allow_i, .req_valid_i,
  .req_ready_o, .req_kind_i, .req_cmd_i, .done_o, .refused_o, .busy_o,
  .cle_o, .ale_o, .chip_sel_n_o, .write_strobe_n_o, .read_strobe_n_o,
  .write_protect_n_o, .io_o, .io_oe_o);

// *** verif/nand_dev_model.sv ***
/* Behavioural NAND device facing the host sequencer pins.
   Assumes strobes only; it has no clock of its own. */
`timescale 1ns/1ps
module nand_dev_model #(
  parameter int BUSY_NS = 500,
  parameter int HOLD_NS = 30
) (
  // strobes
  input  wire logic        cle_i,
  input  wire logic        ale_i,
  input  wire logic        chip_sel_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        write_protect_n_i,
  // bus and status
  input  wire logic [15:0] io_i,
  output logic      [15:0] io_o,
  output logic             ready_busy_n_o,
  // state seen by the bench
  output logic      [7:0]  cmd_o,
  output logic      [2:0]  acnt_o,
  output logic      [39:0] abytes_o,
  output logic      [15:0] din_o,
  output logic      [7:0]  prog_o
);
  logic [15:0] col;
  event        go;
  initial begin
    io_o = 16'h0000;
    ready_busy_n_o = 1'b1;
    cmd_o = 8'h00;
    acnt_o = 3'h0;
    abytes_o = 40'h0;
    din_o = 16'h0000;
    prog_o = 8'h00;
    col = 16'h0000;
  end
  // ==========================================================
  // latch on write strobe rise
  always @(posedge write_strobe_n_i) begin
    if (chip_sel_n_i) begin
    end else if (cle_i && (ready_busy_n_o
        || io_i[7:0] inside {8'hFF, 8'h70, 8'h78})) begin
      cmd_o <= io_i[7:0];
      acnt_o <= 3'h0;
      col <= 16'h0000;
      if (write_protect_n_i && io_i[7:0] inside {8'h10, 8'hD0}) begin
        prog_o <= prog_o + 8'h01;
        -> go;
      end
      if (io_i[7:0] inside {8'h30, 8'h35}) -> go;
    end else if (ale_i && acnt_o < 3'h5) begin
      abytes_o[acnt_o * 8 +: 8] <= io_i[7:0];
      acnt_o <= acnt_o + 3'h1;
    end else if (!cle_i && !ale_i) begin
      din_o <= io_i;
    end
  end
  always @(go) begin
    ready_busy_n_o = 1'b0;
    #(BUSY_NS);
    ready_busy_n_o = 1'b1;
  end
  // ==========================================================
  // data out; a released bus shows the inverse
  always @(negedge read_strobe_n_i) begin
    if (!chip_sel_n_i) begin
      io_o = {~col[7:0], col[7:0]};
      col = col + 16'h0001;
    end
  end
  always @(posedge read_strobe_n_i) begin
    #(HOLD_NS);
    io_o = ~io_o;
  end
endmodule : nand_dev_model

// *** verif/nand_host_seq_tb_top.sv ***
/* Self-checking bench of the host NAND sequencer with a device model.
   Assumes the checker file is compiled alongside for its bind. */
`timescale 1ns/1ps
module nand_host_seq_tb_top;
  logic        sys_clk, rst_b, wm, wpa, valid, ro, co, got_done, got_ref;
  logic [1:0]  kind;
  logic [7:0]  cmd, p;
  logic [30:0] addr, a;
  logic [15:0] wdata;
  logic [31:0] seed;
  wire         ready, done, refused, busy, rb_n, oe;
  wire         cle, ale, cs_n, we_n, re_n, wp_n;
  wire  [15:0] io_h, io_d, rdata, din;
  wire  [15:0] bus = oe ? io_h : io_d;
  wire  [7:0]  mcmd, mprog;
  wire  [2:0]  acnt;
  wire  [39:0] ab;
  int          num_errors, compares, n;
  logic [7:0]  codes [22] = '{8'h00, 8'h05, 8'h06, 8'h10, 8'h11, 8'h30,
    8'h35, 8'h60, 8'h70, 8'h78, 8'h80, 8'h81, 8'h85, 8'h90, 8'hD0,
    8'hD1, 8'hE0, 8'hEC, 8'hED, 8'hEE, 8'hEF, 8'hFF};

  nand_host_seq uut (.sys_clk_i(sys_clk), .rst_b_i(rst_b),
    .word_mode_i(wm), .wp_allow_i(wpa), .req_valid_i(valid),
    .req_ready_o(ready), .req_kind_i(kind), .req_cmd_i(cmd),
    .req_addr_i(addr), .req_row_only_i(ro), .req_col_only_i(co),
    .req_wdata_i(wdata), .done_o(done), .refused_o(refused),
    .rdata_o(rdata), .busy_o(busy), .cle_o(cle), .ale_o(ale),
    .chip_sel_n_o(cs_n), .write_strobe_n_o(we_n),
    .read_strobe_n_o(re_n), .write_protect_n_o(wp_n), .io_o(io_h),
    .io_oe_o(oe), .io_i(bus), .ready_busy_n_i(rb_n));
  nand_dev_model dev (.cle_i(cle), .ale_i(ale), .chip_sel_n_i(cs_n),
    .write_strobe_n_i(we_n), .read_strobe_n_i(re_n),
    .write_protect_n_i(wp_n), .io_i(bus), .io_o(io_d),
    .ready_busy_n_o(rb_n), .cmd_o(mcmd), .acnt_o(acnt), .abytes_o(ab),
    .din_o(din), .prog_o(mprog));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================================
  // expectations and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [39:0] lay(input logic w, input logic [30:0] x);
    if (w) return {5'h00, x[29:11], 5'h00, x[10:0]};
    return {5'h00, x[30:12], 4'h0, x[11:0]};
  endfunction : lay
  task automatic check(input logic ok, input string msg);
    compares++;
    if (!ok) begin
      num_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : check
  task automatic close_out();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic req(input logic [1:0] k, input logic [7:0] c,
      input logic r = 1'b0, input logic q = 1'b0,
      input logic [15:0] w = 16'h0000);
    int i;
    @(posedge sys_clk);
    kind <= k;
    cmd <= c;
    addr <= a;
    ro <= r;
    co <= q;
    wdata <= w;
    valid <= 1'b1;
    @(posedge sys_clk);
    valid <= 1'b0;
    #1;
    for (i = 0; i < 200 && done !== 1'b1 && refused !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    got_done = done;
    got_ref = refused;
    if (i == 200) check(1'b0, "request hang");
    if (i == 200) close_out();
    if (k == 2'h3) @(posedge sys_clk);
    #1;
  endtask : req
  task automatic wait_idle();
    int i;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge sys_clk);
    if (i == 300) check(1'b0, "busy hang");
    if (i == 300) close_out();
  endtask : wait_idle
  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    {wm, valid, ro, co, kind, cmd, addr, wdata, a} = '0;
    wpa = 1'b1;
    seed = 32'hBE524EC2;
    repeat (6) @(posedge sys_clk);
    check(cs_n === 1'b1 && wp_n === 1'b0, "reset pins");
    rst_b <= 1'b1;
    wait_idle();
    foreach (codes[i]) begin
      req(2'h0, codes[i]);
      check(got_done === 1'b1 && mcmd === codes[i], "cmd");
      wait_idle();
    end
    for (n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      a = (n % 4 == 0) ? 31'h7FFFFFFF : seed[30:0];
      a[30] = a[30] & (n < 4);
      @(posedge sys_clk);
      wm <= (n >= 4);
      req(2'h0, 8'h00);
      req(2'h1, 8'h00);
      check(ab === lay(n >= 4, a), "address bytes");
      check(ab[22] === a[n < 4 ? 18 : 17], "plane bit");
    end
    p = mprog;
    req(2'h0, 8'h60);
    req(2'h1, 8'h00, 1'b1);
    check(acnt === 3'h3, "row cycles");
    req(2'h0, 8'hD0);
    check(mprog === p + 8'h01, "erase start");
    wait_idle();
    req(2'h0, 8'h05);
    req(2'h1, 8'h00);
    check(got_ref === 1'b1 && acnt === 3'h0, "random page");
    req(2'h1, 8'h00, 1'b0, 1'b1);
    check(acnt === 3'h2, "column cycles");
    for (n = 0; n < 12; n++) begin
      seed = lfsr(seed);
      p = mcmd;
      if (!(seed[7:0] inside {codes})) req(2'h0, seed[7:0]);
      if (!(seed[7:0] inside {codes})) check(got_ref === 1'b1
        && mcmd === p, "undefined code");
    end
    req(2'h0, 8'h30);
    for (n = 0; n < 20 && busy !== 1'b1; n++) @(posedge sys_clk);
    check(busy === 1'b1, "busy");
    req(2'h0, 8'h90);
    check(got_ref === 1'b1, "busy refuse");
    req(2'h0, 8'h70);
    check(got_done === 1'b1 && mcmd === 8'h70, "busy status");
    wait_idle();
    a = 31'h0;
    req(2'h0, 8'h00);
    req(2'h1, 8'h00);
    req(2'h0, 8'h35);
    wait_idle();
    req(2'h0, 8'h85);
    a[17] = 1'b1;
    req(2'h1, 8'h00);
    check(got_ref === 1'b1 && acnt === 3'h0, "cb other plane");
    a[17] = 1'b0;
    req(2'h1, 8'h00);
    check(got_done === 1'b1 && acnt === 3'h5, "cb same plane");
    @(posedge sys_clk);
    wpa <= 1'b0;
    p = mprog;
    req(2'h0, 8'h80);
    check(got_ref === 1'b1, "wp program");
    req(2'h0, 8'hD0);
    check(got_ref === 1'b1 && mprog === p, "wp erase");
    req(2'h0, 8'h00);
    check(got_done === 1'b1, "wp read");
    @(posedge sys_clk);
    wpa <= 1'b1;
    seed = lfsr(seed);
    req(2'h0, 8'h80);
    req(2'h2, 8'h00, 1'b0, 1'b0, seed[15:0]);
    check(din === seed[15:0], "data in");
    req(2'h0, 8'h00);
    for (n = 0; n < 3; n++) begin
      req(2'h3, 8'h00);
      check(rdata === {~n[7:0], n[7:0]}, "data out");
    end
    @(posedge sys_clk);
    wm <= 1'b0;
    req(2'h3, 8'h00);
    check(rdata === 16'h0003, "byte data out");
    close_out();
  end
endmodule : nand_host_seq_tb_top
